// file: core/ffa_pkg.sv
// fault flag aggregator: shared constants for both ends of the serial link
// assumes: one 50 MHz system clock on each end, frames of fixed length
package ffa_pkg;

	// ****************************************************************
	// timing
	// ****************************************************************
	localparam int SYS_PERIOD_NS  = 20;
	localparam int LINK_PERIOD_NS = 160;
	localparam int LINK_HALF_CYC  = LINK_PERIOD_NS / (2 * SYS_PERIOD_NS);

	// ****************************************************************
	// frame layout, host word {rw, 7'h00, addr, data, 8'h00}
	// ****************************************************************
	localparam int FRAME_BITS = 40;
	localparam int FR_RW      = 39;
	localparam int FR_ADDR_LO = 24;
	localparam int FR_DATA_LO = 8;

	// ****************************************************************
	// register addresses
	// ****************************************************************
	localparam logic [7:0] A_STATUS_MSB = 8'h00;
	localparam logic [7:0] A_STATUS_LSB = 8'h01;
	localparam logic [7:0] A_DET_BASE   = 8'h02;	// power, timing, logic detail
	localparam logic [7:0] A_EN_BASE    = 8'h05;
	localparam logic [7:0] A_MASK_BASE  = 8'h08;
	localparam logic [7:0] A_DIAG_BASE  = 8'h0B;
	localparam logic [7:0] A_MEM_PAT    = 8'h0E;
	localparam logic [7:0] A_PIN_CFG    = 8'h0F;
	localparam logic [7:0] A_PIN_MASK   = 8'h10;
	localparam logic [7:0] A_TOP        = 8'hFF;

	// ****************************************************************
	// field positions and reset values
	// ****************************************************************
	localparam int ST_RESET   = 15;
	localparam int ST_GROUP0  = 14;	// groups occupy 14, 13, 12
	localparam int ST_RACC    = 11;
	localparam int ST_FLEN    = 10;
	localparam int ST_PIN_HI  = 14;
	localparam int ST_PIN_LO  = 7;
	localparam int CFG_DIR    = 0;
	localparam int CFG_SRC    = 1;
	localparam int CFG_FMT    = 2;
	localparam int CFG_POL    = 3;
	localparam int CFG_DAT    = 4;
	localparam int LOG_OTP    = 8;
	localparam logic [7:0] EN_RST   = 8'hFF;
	localparam logic [7:0] MASK_RST = 8'h00;
	localparam logic [4:0] CFG_RST  = 5'h00;

	// ****************************************************************
	// command response codes
	// ****************************************************************
	localparam logic [3:0] RESP_NONE  = 4'h0;
	localparam logic [3:0] RESP_READ  = 4'h1;
	localparam logic [3:0] RESP_WRITE = 4'h2;
	localparam logic [3:0] RESP_ADDR  = 4'h4;
	localparam logic [3:0] RESP_LEN   = 4'h8;

	// host command port addresses
	localparam logic [1:0] H_CMD    = 2'h0;
	localparam logic [1:0] H_STATUS = 2'h1;
	localparam logic [1:0] H_RESP   = 2'h2;

endpackage

// file: core/ffa_link_if.sv
// fault flag aggregator: serial link between host and device
// assumes: host makes the link clock, bench joins the modports
`timescale 1ns/1ps
`default_nettype none
interface ffa_link_if;
	logic sclk;
	logic cs_n;
	logic mosi;
	logic miso;
	modport host (output sclk, output cs_n, output mosi, input miso);
	modport dev  (input sclk, input cs_n, input mosi, output miso);
endinterface
`default_nettype wire

// file: core/ffa_device.sv
// fault flag aggregator, device end: sticky monitor flags, group flags,
// fault pin and register access over the serial link
// assumes: link pins and monitor outputs are asynchronous and are synchronised here
//
// How it works
// - address FFh raises register access flag
// - other unknown addresses raise nothing
// - unknown read returns zero data, zero address
// - each monitor flag goes low on fault
// - primary status word leads every frame
// - group flag low on any unmasked detail
// - group clear needs all detail flags one
// - masked detail flags still show in detail
// - disabled monitor reports no fault anywhere, except the memory check on logic bit 0
// - pin is fault output when dir=1, src=0
// - pin active while unmasked status flag low
// - polarity and format choose pin levels
// - pin mask blocks eight flags from pin
// - selftest bit injects fault into monitor
// - host never runs both clock selftests
// - host follows documented selftest sequence
// - two-bit pattern injects into memory check
// - each frame carries previous command response
// - read-only indicators for lock, clock, mode, sequence
// - load bank 0, else bank 1, report
// - no bank usable drives memory flag low
// - writing one clears flag, zero ignored
//
// The plain strobed port and the register addresses were decided locally.
`timescale 1ns/1ps
`default_nettype none
module ffa_device #(
	parameter int MON_W = 8,
	parameter int HB_BITS = 6
) (
	// clock and reset
	input  wire logic             i_clk_sys,
	input  wire logic             i_rst_b,
	// link
	ffa_link_if.dev               link,
	// monitor outputs, low on fault: power, timing, logic groups
	input  wire logic [MON_W-1:0] i_power_mon_n,
	input  wire logic [MON_W-1:0] i_timing_mon_n,
	input  wire logic [MON_W-1:0] i_logic_mon_n,
	// otp bank outcome, valid at reset release
	input  wire logic             i_otp_bank0_ok,
	input  wire logic             i_otp_bank1_ok,
	// indicators from the rest of the device
	input  wire logic             i_lock,
	input  wire logic             i_clock_external,
	input  wire logic [1:0]       i_mode,
	input  wire logic             i_mux_converter_sequence_running,
	// selftest requests toward the monitors
	output logic [MON_W-1:0]      o_power_selftest,
	output logic [MON_W-1:0]      o_timing_selftest,
	output logic [MON_W-1:0]      o_logic_selftest,
	output logic [1:0]            o_memory_check_inject_pattern,
	// shared pin
	input  wire logic             i_shared_pin,
	output logic                  o_shared_pin,
	output logic                  o_shared_pin_oe
);
	// refused at elaboration: status bit 8 of the logic group holds the bank
	if (MON_W < 1 || MON_W > 8) begin : g_bad_mon_w
		$error("MON_W must be 1..8");
	end
	if (HB_BITS < 1) begin : g_bad_hb_bits
		$error("HB_BITS must be at least 1");
	end

	// ****************************************************************
	// synchronisers: first stage read only by second stage
	// ****************************************************************
	logic [3:0]           lk_s1_r, lk_s2_r;	// {pin, mosi, cs_n, sclk}
	logic [3*MON_W-1:0]   mon_s1_r, mon_s2_r;
	logic                 sclk_d_r, cs_d_r;
	always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
		if (!i_rst_b) begin
			// idle levels, so no false link edge follows reset
			lk_s1_r  <= 4'h2;
			lk_s2_r  <= 4'h2;
			mon_s1_r <= '1;
			mon_s2_r <= '1;
			sclk_d_r <= 1'b0;
			cs_d_r   <= 1'b1;
		end else begin
			lk_s1_r  <= {i_shared_pin, link.mosi, link.cs_n, link.sclk};
			lk_s2_r  <= lk_s1_r;
			mon_s1_r <= {i_logic_mon_n, i_timing_mon_n, i_power_mon_n};
			mon_s2_r <= mon_s1_r;
			sclk_d_r <= lk_s2_r[0];
			cs_d_r   <= lk_s2_r[1];
		end
	end
	wire logic sclk_rise = lk_s2_r[0] & ~sclk_d_r;
	wire logic sclk_fall = ~lk_s2_r[0] & sclk_d_r;
	wire logic cs_fall   = ~lk_s2_r[1] & cs_d_r;
	wire logic cs_rise   = lk_s2_r[1] & ~cs_d_r;

	// ****************************************************************
	// registers and frame state
	// ****************************************************************
	logic [MON_W-1:0] det_r  [0:2];
	logic [MON_W-1:0] en_r   [0:2];
	logic [MON_W-1:0] mask_r [0:2];
	logic [MON_W-1:0] diag_r [0:2];
	logic [2:0]       grp_r;
	logic             rst_flag_r, racc_r, flen_r, otp_bank_r, otp_fail_r, otp_done_r;
	logic [1:0]       pat_r;
	logic [4:0]       cfg_r;
	logic [7:0]       pin_mask_r;
	logic [3:0]       resp_r;
	logic [7:0]       resp_addr_r;
	logic [15:0]      resp_data_r;
	localparam int FRAME_BITS_W = ffa_pkg::FRAME_BITS;
	logic [FRAME_BITS_W-1:0] in_sh_r, out_sh_r;
	logic [5:0]       bitcnt_r;

	// decoded command at the end of a frame
	wire logic        frame_ok = (bitcnt_r == 6'(ffa_pkg::FRAME_BITS));
	wire logic        exec     = cs_rise & frame_ok;
	wire logic        cmd_rw   = in_sh_r[ffa_pkg::FR_RW];
	wire logic [7:0]  cmd_addr = in_sh_r[ffa_pkg::FR_ADDR_LO +: 8];
	wire logic [15:0] cmd_data = in_sh_r[ffa_pkg::FR_DATA_LO +: 16];
	wire logic        wr       = exec & ~cmd_rw;
	wire logic        at_top   = (cmd_addr >= ffa_pkg::A_TOP);

	// one-hot select of a per-group register from a base address
	function automatic logic [2:0] grp_sel(input logic [7:0] a, input logic [7:0] base);
		grp_sel = {a == base + 8'h02, a == base + 8'h01, a == base};
	endfunction
	wire logic [2:0] sel_det  = grp_sel(cmd_addr, ffa_pkg::A_DET_BASE);
	wire logic [2:0] sel_en   = grp_sel(cmd_addr, ffa_pkg::A_EN_BASE);
	wire logic [2:0] sel_mask = grp_sel(cmd_addr, ffa_pkg::A_MASK_BASE);
	wire logic [2:0] sel_diag = grp_sel(cmd_addr, ffa_pkg::A_DIAG_BASE);

	// ****************************************************************
	// fault detection per group
	// ****************************************************************
	logic [MON_W-1:0] fault_now [0:2];
	logic [MON_W-1:0] en_eff    [0:2];
	logic [15:0]      status_word;
	always_comb begin
		for (int g = 0; g < 3; g++) begin
			en_eff[g]    = en_r[g];
			fault_now[g] = en_r[g] & (~mon_s2_r[g*MON_W +: MON_W] | diag_r[g]);
		end
		// memory check always runs; pattern and otp loss force its fault
		en_eff[2][0]    = 1'b1;
		fault_now[2][0] = ~mon_s2_r[2*MON_W] | (pat_r != 2'h0) | otp_fail_r;
	end

	// detail flags: sticky low, cleared by writing one, fault wins
	always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
		if (!i_rst_b) begin
			for (int g = 0; g < 3; g++) det_r[g] <= '1;
		end else begin
			for (int g = 0; g < 3; g++) begin
				det_r[g] <= (det_r[g]
					| ((wr && sel_det[g])
						? cmd_data[MON_W-1:0] : '0)
					| ~en_eff[g])
					& ~fault_now[g];
			end
		end
	end

	// group flags: low on any unmasked detail, clear only when detail clean
	always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
		if (!i_rst_b) begin
			grp_r <= 3'h7;
		end else begin
			for (int g = 0; g < 3; g++) begin
				grp_r[g] <= (grp_r[g] | (wr && cmd_addr == ffa_pkg::A_STATUS_MSB
					&& cmd_data[ffa_pkg::ST_GROUP0 - g] && (&det_r[g])))
					& ~(|(~det_r[g] & ~mask_r[g]));
			end
		end
	end

	// communication flags in the primary status word
	always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
		if (!i_rst_b) begin
			rst_flag_r <= 1'b0;
			racc_r     <= 1'b1;
			flen_r     <= 1'b1;
		end else begin
			if (wr && cmd_addr == ffa_pkg::A_STATUS_MSB) begin
				rst_flag_r <= rst_flag_r | cmd_data[ffa_pkg::ST_RESET];
			end
			racc_r <= (racc_r | (wr && cmd_addr == ffa_pkg::A_STATUS_MSB
				&& cmd_data[ffa_pkg::ST_RACC])) & ~(exec & at_top);
			flen_r <= (flen_r | (wr && cmd_addr == ffa_pkg::A_STATUS_MSB
				&& cmd_data[ffa_pkg::ST_FLEN])) & ~(cs_rise & ~frame_ok);
		end
	end

	// ****************************************************************
	// otp bank choice, caught once after reset release
	// ****************************************************************
	always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
		if (!i_rst_b) begin
			otp_done_r <= 1'b0;
			otp_bank_r <= 1'b0;
			otp_fail_r <= 1'b0;
		end else if (!otp_done_r) begin
			otp_done_r <= 1'b1;
			otp_bank_r <= ~i_otp_bank0_ok;
			otp_fail_r <= ~i_otp_bank0_ok & ~i_otp_bank1_ok;
		end
	end

	// ****************************************************************
	// configuration registers
	// ****************************************************************
	always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
		if (!i_rst_b) begin
			for (int g = 0; g < 3; g++) begin
				en_r[g]   <= ffa_pkg::EN_RST[MON_W-1:0];
				mask_r[g] <= ffa_pkg::MASK_RST[MON_W-1:0];
				diag_r[g] <= '0;
			end
			pat_r      <= 2'h0;
			cfg_r      <= ffa_pkg::CFG_RST;
			pin_mask_r <= ffa_pkg::MASK_RST;
		end else if (wr) begin
			for (int g = 0; g < 3; g++) begin
				if (sel_en[g]) en_r[g] <= cmd_data[MON_W-1:0];
				if (sel_mask[g]) mask_r[g] <= cmd_data[MON_W-1:0];
				if (sel_diag[g]) diag_r[g] <= cmd_data[MON_W-1:0];
			end
			if (cmd_addr == ffa_pkg::A_MEM_PAT) pat_r <= cmd_data[1:0];
			if (cmd_addr == ffa_pkg::A_PIN_CFG) cfg_r <= cmd_data[4:0];
			if (cmd_addr == ffa_pkg::A_PIN_MASK) pin_mask_r <= cmd_data[7:0];
		end
	end

	// ****************************************************************
	// read decode: unknown addresses answer zero and echo zero
	// ****************************************************************
	assign status_word = {rst_flag_r, grp_r[0], grp_r[1], grp_r[2], racc_r, flen_r,
		3'h7, 3'h0, resp_r};
	logic        rd_hit;
	logic [15:0] rd_data;
	always_comb begin
		rd_hit  = 1'b1;
		rd_data = 16'h0000;
		if (cmd_addr == ffa_pkg::A_STATUS_MSB) rd_data = status_word;
		else if (cmd_addr == ffa_pkg::A_STATUS_LSB)
			rd_data = {10'h000, lk_s2_r[3], i_mux_converter_sequence_running, i_mode,
				i_clock_external, i_lock};
		else if (cmd_addr == ffa_pkg::A_MEM_PAT) rd_data = {14'h0000, pat_r};
		else if (cmd_addr == ffa_pkg::A_PIN_CFG) rd_data = {11'h000, cfg_r};
		else if (cmd_addr == ffa_pkg::A_PIN_MASK) rd_data = {8'h00, pin_mask_r};
		else rd_hit = 1'b0;
		for (int g = 0; g < 3; g++) begin
			if (sel_det[g]) begin
				rd_hit  = 1'b1;
				rd_data = 16'(det_r[g]);
				if (g == 2) rd_data[ffa_pkg::LOG_OTP] = otp_bank_r;
			end
			if (sel_en[g]) begin
				rd_hit  = 1'b1;
				rd_data = 16'(en_r[g]);
			end
			if (sel_mask[g]) begin
				rd_hit  = 1'b1;
				rd_data = 16'(mask_r[g]);
			end
			if (sel_diag[g]) begin
				rd_hit  = 1'b1;
				rd_data = 16'(diag_r[g]);
			end
		end
	end

	// answer of the last frame, sent in the next one
	always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
		if (!i_rst_b) begin
			resp_r      <= ffa_pkg::RESP_NONE;
			resp_addr_r <= 8'h00;
			resp_data_r <= 16'h0000;
		end else if (cs_rise) begin
			resp_addr_r <= 8'h00;
			resp_data_r <= 16'h0000;
			if (!frame_ok) begin
				resp_r <= ffa_pkg::RESP_LEN;
			end else if (at_top) begin
				resp_r <= ffa_pkg::RESP_ADDR;
			end else if (cmd_rw) begin
				resp_r <= ffa_pkg::RESP_READ;
				if (rd_hit) begin
					resp_addr_r <= cmd_addr;
					resp_data_r <= rd_data;
				end
			end else begin
				resp_r <= ffa_pkg::RESP_WRITE;
			end
		end
	end

	// ****************************************************************
	// frame shifter: sample on rising link clock, shift out on falling
	// ****************************************************************
	always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
		if (!i_rst_b) begin
			in_sh_r  <= '0;
			out_sh_r <= '0;
			bitcnt_r <= 6'h00;
		end else if (cs_fall) begin
			out_sh_r <= {status_word, resp_addr_r, resp_data_r};
			bitcnt_r <= 6'h00;
		end else if (!lk_s2_r[1]) begin
			if (sclk_rise) begin
				in_sh_r  <= {in_sh_r[FRAME_BITS_W-2:0], lk_s2_r[2]};
				bitcnt_r <= (bitcnt_r == 6'h3F) ? bitcnt_r : bitcnt_r + 6'h01;
			end
			if (sclk_fall) out_sh_r <= {out_sh_r[FRAME_BITS_W-2:0], 1'b0};
		end
	end
	assign link.miso = out_sh_r[FRAME_BITS_W-1];

	// ****************************************************************
	// shared pin: fault output or plain data, heartbeat when idle
	// ****************************************************************
	logic [HB_BITS-1:0] hb_r;
	wire logic pin_active = |(~status_word[ffa_pkg::ST_PIN_HI:ffa_pkg::ST_PIN_LO]
		& ~pin_mask_r);
	always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
		if (!i_rst_b) begin
			hb_r            <= '0;
			o_shared_pin    <= 1'b0;
			o_shared_pin_oe <= 1'b0;
		end else begin
			hb_r            <= hb_r + 1'b1;
			o_shared_pin_oe <= cfg_r[ffa_pkg::CFG_DIR];
			if (cfg_r[ffa_pkg::CFG_SRC]) o_shared_pin <= cfg_r[ffa_pkg::CFG_DAT];
			else if (pin_active) o_shared_pin <= cfg_r[ffa_pkg::CFG_POL];
			else if (cfg_r[ffa_pkg::CFG_FMT]) o_shared_pin <= hb_r[HB_BITS-1];
			else o_shared_pin <= ~cfg_r[ffa_pkg::CFG_POL];
		end
	end

	// selftest requests out to the monitor circuits
	assign o_power_selftest              = diag_r[0];
	assign o_timing_selftest             = diag_r[1];
	assign o_logic_selftest              = diag_r[2];
	assign o_memory_check_inject_pattern = pat_r;
endmodule // ffa_device
`default_nettype wire

// file: core/ffa_host.sv
// fault flag aggregator, host end: runs one link frame per command
// assumes: software drives the plain command port on the same clock
`timescale 1ns/1ps
`default_nettype none
module ffa_host #(
	parameter int HALF_CYC = ffa_pkg::LINK_HALF_CYC
) (
	// clock and reset
	input  wire logic        i_clk_sys,
	input  wire logic        i_rst_b,
	// command port
	input  wire logic [1:0]  i_addr,
	input  wire logic [31:0] i_wdata,
	input  wire logic        i_wr,
	input  wire logic        i_rd,
	output logic      [31:0] o_rdata,
	// link
	ffa_link_if.host         link
);
	// the half period counter is eight bits wide
	if (HALF_CYC < 4 || HALF_CYC > 256) begin : g_bad_half_cyc
		$error("HALF_CYC must be 4..256");
	end

	typedef enum logic [4:0] {
		FFA_IDLE  = 5'b00001,
		FFA_LEAD  = 5'b00010,
		FFA_SHIFT = 5'b00100,
		FFA_TAIL  = 5'b01000,
		FFA_GAP   = 5'b10000
	} ffa_hstate_t;

	localparam int NB = ffa_pkg::FRAME_BITS;
	ffa_hstate_t  st_r;
	logic [7:0]   hc_r;
	logic [5:0]   nb_r;
	logic [NB-1:0] out_r, in_r;
	logic         miso_s1_r, miso_s2_r;
	logic [NB-1:0] last_r;
	wire logic    half_end = (hc_r == 8'(HALF_CYC - 1));
	// a command is taken only while idle; others are dropped
	wire logic    start = i_wr && i_addr == ffa_pkg::H_CMD && st_r == FFA_IDLE;

	// ****************************************************************
	// miso synchroniser
	// ****************************************************************
	always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
		if (!i_rst_b) begin
			miso_s1_r <= 1'b0;
			miso_s2_r <= 1'b0;
		end else begin
			miso_s1_r <= link.miso;
			miso_s2_r <= miso_s1_r;
		end
	end

	// ****************************************************************
	// frame sequencer; link clock made by dividing the system clock
	// ****************************************************************
	always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
		if (!i_rst_b) begin
			st_r      <= FFA_IDLE;
			hc_r      <= 8'h00;
			nb_r      <= 6'h00;
			out_r     <= '0;
			in_r      <= '0;
			last_r    <= '0;
			link.sclk <= 1'b0;
			link.cs_n <= 1'b1;
		end else begin
			hc_r <= (st_r == FFA_IDLE || half_end) ? 8'h00 : hc_r + 8'h01;
			unique case (st_r)
				FFA_IDLE: begin
					if (start) begin
						out_r     <= {i_wdata[24], 7'h00, i_wdata[23:16], i_wdata[15:0], 8'h00};
						link.cs_n <= 1'b0;
						nb_r      <= 6'h00;
						st_r      <= FFA_LEAD;
					end
				end
				FFA_LEAD: begin
					if (half_end) begin
						link.sclk <= 1'b1;
						st_r      <= FFA_SHIFT;
					end
				end
				FFA_SHIFT: begin
					if (half_end) begin
						if (link.sclk) begin
							// sample late in the high phase, after device settles
							in_r      <= {in_r[NB-2:0], miso_s2_r};
							out_r     <= {out_r[NB-2:0], 1'b0};
							nb_r      <= nb_r + 6'h01;
							link.sclk <= 1'b0;
							if (nb_r == 6'(NB - 1)) st_r <= FFA_TAIL;
						end else begin
							link.sclk <= 1'b1;
						end
					end
				end
				FFA_TAIL: begin
					if (half_end) begin
						link.cs_n <= 1'b1;
						last_r    <= in_r;
						st_r      <= FFA_GAP;
					end
				end
				FFA_GAP: begin
					if (half_end) st_r <= FFA_IDLE;
				end
			endcase
		end
	end
	assign link.mosi = out_r[NB-1];

	// ****************************************************************
	// command port read data, one cycle after the strobe
	// ****************************************************************
	always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
		if (!i_rst_b) begin
			o_rdata <= 32'h0000_0000;
		end else if (i_rd) begin
			unique case (i_addr)
				ffa_pkg::H_CMD:    o_rdata <= {31'h0000_0000, st_r != FFA_IDLE};
				ffa_pkg::H_STATUS: o_rdata <= {16'h0000, last_r[39:24]};
				ffa_pkg::H_RESP:   o_rdata <= {8'h00, last_r[23:0]};
				default:           o_rdata <= 32'h0000_0000;
			endcase
		end
	end
endmodule // ffa_host
`default_nettype wire

// file: tb/ffa_link_properties.sv
// checker for the serial link between host and device ends
// assumes: link half period of 4 system cycles, one system clock
`timescale 1ns/1ps
`default_nettype none
module ffa_link_properties (
	// clock and reset
	input wire logic i_clk_sys,
	input wire logic i_rst_b,
	// link signals
	input wire logic sclk,
	input wire logic cs_n,
	input wire logic mosi,
	input wire logic miso
);
	default clocking cb @(posedge i_clk_sys); endclocking
	default disable iff (!i_rst_b);

	// ************************************
	// rising link edges seen in this frame
	// ************************************
	logic [5:0] n_rise_r;

	// cleared between frames so a short frame cannot borrow edges
	always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
		if (!i_rst_b)
			n_rise_r <= 6'h00;
		else if (cs_n)
			n_rise_r <= 6'h00;
		else if ($rose(sclk))
			n_rise_r <= n_rise_r + 6'h01;
	end

	// ************************************
	// properties
	// ************************************
	a_clk_idle_low: assert property (cs_n |-> !sclk)
		else $error("link clock moves outside a frame");
	a_frame_gap: assert property ($rose(cs_n) |-> cs_n[*4])
		else $error("frame gap shorter than 4 cycles");
	a_frame_start: assert property ($fell(cs_n) |-> !sclk[*4] ##1 sclk)
		else $error("first link edge misplaced");
	a_high_half: assert property ($rose(sclk) |-> sclk[*4] ##1 !sclk)
		else $error("link clock high time wrong");
	a_low_half: assert property ($fell(sclk) && n_rise_r != 6'h28 |-> !sclk[*4] ##1 sclk)
		else $error("link clock low time wrong");
	a_frame_len: assert property ($rose(cs_n) |-> n_rise_r == 6'h28)
		else $error("frame not 40 bits");
	a_status_ones: assert property ($rose(sclk) && n_rise_r inside {[6:8]} |-> miso)
		else $error("status bits 9 to 7 not one");
	a_status_zeros: assert property ($rose(sclk) && n_rise_r inside {[9:11]} |-> !miso)
		else $error("status bits 6 to 4 not zero");
	a_mosi_idle: assert property (cs_n |-> !mosi)
		else $error("host data not low outside a frame");
endmodule // ffa_link_properties
`default_nettype wire

// file: tb/tb_top.sv
// bench: host and device ends joined by the link, driven via the command port
// assumes: package, interface and both ends compiled before this file
`timescale 1ns/1ps
`default_nettype none
module tb_top;
	logic        i_clk_sys, i_rst_b, wr, rd, pin, oe, pin_w, ob1;
	logic [1:0]  addr, pat;
	logic [31:0] wdata, rdata, r;
	logic [7:0]  pw_n, tm_n, lg_n, st;
	logic [5:0]  ind;
	logic [2:0]  i;
	int          err_total, n_checks;
	ffa_link_if  lnk();

	// no pull on the pin, so an undriven pin reads low
	assign pin_w = oe ? pin : 1'h0;
	// selftest loops back into the power monitors
	ffa_host i_ffa_host (.i_clk_sys, .i_rst_b, .i_addr(addr), .i_wdata(wdata), .i_wr(wr),
		.i_rd(rd), .o_rdata(rdata), .link(lnk.host));
	ffa_device #(.HB_BITS(4)) i_ffa_device (.i_clk_sys, .i_rst_b, .link(lnk.dev),
		.i_power_mon_n(pw_n & ~st), .i_timing_mon_n(tm_n), .i_logic_mon_n(lg_n),
		.i_otp_bank0_ok(ind[5]), .i_otp_bank1_ok(ob1), .i_lock(ind[0]),
		.i_clock_external(ind[1]), .i_mode(ind[3:2]),
		.i_mux_converter_sequence_running(ind[4]), .o_power_selftest(st),
		.o_timing_selftest(), .o_logic_selftest(), .o_memory_check_inject_pattern(pat),
		.i_shared_pin(pin_w), .o_shared_pin(pin), .o_shared_pin_oe(oe));
	ffa_link_properties i_ffa_link_properties (.i_clk_sys, .i_rst_b, .sclk(lnk.sclk),
		.cs_n(lnk.cs_n), .mosi(lnk.mosi), .miso(lnk.miso));

	initial begin
		i_clk_sys = 1'h0;
		forever #10 i_clk_sys = ~i_clk_sys;
	end

	// ************************************
	// helpers
	// ************************************
	function automatic logic [31:0] stw(logic rf, logic [2:0] g, logic ra, logic [3:0] rs);
		return {16'h0000, rf, g, ra, 1'h1, 3'h7, 3'h0, rs};
	endfunction
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_checks++;
		if (got !== exp) begin
			err_total++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic complete_run;
		$display("checks=%0d errors=%0d", n_checks, err_total);
		if (err_total == 0 && n_checks > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	// host port read, data lands in r
	task automatic hrd(input logic [1:0] a);
		@(posedge i_clk_sys);
		rd <= 1'h1;
		addr <= a;
		@(posedge i_clk_sys);
		rd <= 1'h0;
		#1 r = rdata;
	endtask
	// one link frame, waits on busy with a bound
	task automatic frm(input logic rw, input logic [7:0] a, input logic [15:0] d);
		int k;
		@(posedge i_clk_sys);
		wr <= 1'h1;
		addr <= ffa_pkg::H_CMD;
		wdata <= {7'h00, rw, a, d};
		@(posedge i_clk_sys);
		wr <= 1'h0;
		for (k = 0; k < 600; k++) begin
			hrd(ffa_pkg::H_CMD);
			if (r[0] === 1'h0)
				break;
		end
		if (k == 600) begin
			err_total++;
			complete_run();
		end
	endtask
	// the answer to a read comes back in the following frame
	task automatic drd(input logic [7:0] a);
		frm(1'h1, a, 16'h0000);
		frm(1'h1, a, 16'h0000);
		hrd(ffa_pkg::H_RESP);
	endtask

	// ************************************
	// main sequence
	// ************************************
	initial begin
		void'($urandom(32'hEAA8814E));
		{i_rst_b, wr, rd, addr, wdata} = '0;
		{pw_n, tm_n, lg_n, ob1} = '1;
		ind = 6'($urandom);
		i = 3'($urandom);
		repeat (4) @(posedge i_clk_sys);
		i_rst_b <= 1'h1;
		drd(ffa_pkg::A_STATUS_LSB);
		chk({26'h0, r[5:0]}, {26'h0, 1'h0, ind[4:0]});
		hrd(ffa_pkg::H_STATUS);
		chk(r & 32'hFFFF, stw(1'h0, 3'h7, 1'h1, 4'h1));
		// clear the reset flag, then hit the top address and a hole
		frm(1'h0, ffa_pkg::A_STATUS_MSB, 16'h8000);
		frm(1'h1, ffa_pkg::A_TOP, 16'h0000);
		frm(1'h0, ffa_pkg::A_STATUS_MSB, 16'h0000);
		hrd(ffa_pkg::H_STATUS);
		chk(r & 32'hFFFF, stw(1'h1, 3'h7, 1'h0, 4'h4));
		frm(1'h0, ffa_pkg::A_STATUS_MSB, 16'h0800);
		drd(8'h20);
		chk(r & 32'hFFFFFF, 32'h0);
		hrd(ffa_pkg::H_STATUS);
		chk(r & 32'hFFFF, stw(1'h1, 3'h7, 1'h1, 4'h1));
		// fault i live, i+1 masked, i+2 disabled; pin static, active low
		frm(1'h0, ffa_pkg::A_MASK_BASE, 16'(8'h01 << 3'(i + 3'h1)));
		frm(1'h0, ffa_pkg::A_EN_BASE, 16'(~(8'h01 << 3'(i + 3'h2))));
		frm(1'h0, ffa_pkg::A_PIN_CFG, 16'h0001);
		pw_n <= ~((8'h01 << i) | (8'h01 << 3'(i + 3'h1)) | (8'h01 << 3'(i + 3'h2)));
		repeat (6) @(posedge i_clk_sys);
		pw_n <= 8'hFF;
		drd(ffa_pkg::A_DET_BASE);
		chk({24'h0, r[7:0]}, {24'h0, ~((8'h01 << i) | (8'h01 << 3'(i + 3'h1)))});
		hrd(ffa_pkg::H_STATUS);
		chk(r & 32'hFFFF, stw(1'h1, 3'h3, 1'h1, 4'h1));
		chk({30'h0, oe, pin}, 32'h2);
		// group clear refused while detail still low
		frm(1'h0, ffa_pkg::A_STATUS_MSB, 16'h4000);
		frm(1'h0, ffa_pkg::A_DET_BASE, 16'h00FF);
		hrd(ffa_pkg::H_STATUS);
		chk(r & 32'hFFFF, stw(1'h1, 3'h3, 1'h1, 4'h2));
		frm(1'h0, ffa_pkg::A_STATUS_MSB, 16'h4000);
		drd(ffa_pkg::A_DET_BASE);
		chk({24'h0, r[7:0]}, 32'hFF);
		hrd(ffa_pkg::H_STATUS);
		chk(r & 32'hFFFF, stw(1'h1, 3'h7, 1'h1, 4'h1));
		chk({30'h0, oe, pin}, 32'h3);
		// pin mask on the power group, then selftest injects a fault
		frm(1'h0, ffa_pkg::A_PIN_MASK, 16'h0080);
		frm(1'h0, ffa_pkg::A_DIAG_BASE, 16'(8'h01 << i));
		chk({24'h0, st}, {24'h0, 8'h01 << i});
		drd(ffa_pkg::A_DET_BASE);
		chk({24'h0, r[7:0]}, {24'h0, ~(8'h01 << i)});
		chk({30'h0, oe, pin}, 32'h3);
		// end the selftest: monitor and selftest off, clear, monitor on
		frm(1'h0, ffa_pkg::A_EN_BASE, 16'h0000);
		frm(1'h0, ffa_pkg::A_DIAG_BASE, 16'h0000);
		chk({24'h0, st}, 32'h0);
		frm(1'h0, ffa_pkg::A_DET_BASE, 16'h00FF);
		frm(1'h0, ffa_pkg::A_EN_BASE, 16'h00FF);
		drd(ffa_pkg::A_DET_BASE);
		chk({24'h0, r[7:0]}, 32'hFF);
		frm(1'h0, ffa_pkg::A_PIN_MASK, 16'h0000);
		frm(1'h0, ffa_pkg::A_PIN_CFG, 16'h0009);
		repeat (4) @(posedge i_clk_sys);
		chk({30'h0, oe, pin}, 32'h3);
		// data source wins over an active fault, then heartbeat when masked
		frm(1'h0, ffa_pkg::A_PIN_CFG, 16'h000B);
		chk({30'h0, oe, pin}, 32'h2);
		frm(1'h0, ffa_pkg::A_PIN_CFG, 16'h0005);
		frm(1'h0, ffa_pkg::A_PIN_MASK, 16'h0080);
		r = {31'h0, pin};
		repeat (8) @(posedge i_clk_sys);
		#1 chk({31'h0, pin}, {31'h0, ~r[0]});
		// every inject pattern, last one holds the memory flag low
		for (int p = 0; p < 4; p++) begin
			frm(1'h0, ffa_pkg::A_MEM_PAT, 16'(p));
			chk({30'h0, pat}, 32'(p));
		end
		drd(8'h04);
		chk({23'h0, r[8:0]}, {23'h0, ~ind[5], 8'hFE});
		// second reset with both banks lost holds the memory flag low
		ind[5] <= 1'h0;
		ob1 <= 1'h0;
		i_rst_b <= 1'h0;
		repeat (4) @(posedge i_clk_sys);
		i_rst_b <= 1'h1;
		drd(8'h04);
		chk({23'h0, r[8:0]}, 32'h1FE);
		complete_run();
	end
endmodule // tb_top
`default_nettype wire
